// ### include/pbei_pkg.sv
// Purpose: shared constants and types for the power button event input block
// Assumes: 20 MHz always-on clock, AXI4-Lite register access
// Notes: times are kept in their own unit; cycle counts derive from the clock rate
package pbei_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned DB_MS = 16;
  localparam int unsigned FAST_US = 500;
  localparam int unsigned S0_START_US = 100;
  localparam int unsigned WAKE_MIN_US = 150;
  localparam int unsigned REL_MIN_US = 500;
  localparam int unsigned OVR_S = 4;
  localparam int unsigned OVR_EXT_S = 9;
  localparam int unsigned RST_MS = 5;
  localparam int unsigned DB_CYC = DB_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_CYC = FAST_US * (CLK_HZ / 1000000);
  localparam int unsigned S0_START_CYC = S0_START_US * (CLK_HZ / 1000000);
  localparam int unsigned WAKE_MIN_CYC = WAKE_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned REL_MIN_CYC = REL_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned OVR_CYC = OVR_S * CLK_HZ;
  localparam int unsigned OVR_EXT_CYC = OVR_EXT_S * CLK_HZ;
  localparam int unsigned RST_CYC = RST_MS * (CLK_HZ / 1000);
  // register byte addresses
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STS = 8'h04;
  localparam logic [7:0] ADDR_LVL = 8'h08;
  // config field positions
  localparam int CFG_DB_MODE = 0;
  localparam int CFG_SCI_ROUTE_ENABLE = 1;
  localparam int CFG_BTN_EN = 2;
  localparam int CFG_GSMI_EN = 3;
  localparam int CFG_WAKE_EN = 4;
  localparam int CFG_INT_WAKE = 5;
  localparam int CFG_FULL_CYC = 6;
  localparam logic [6:0] CFG_RST = 7'h00;
  // status field positions, write one to clear
  localparam int STS_BTN = 0;
  localparam int STS_WAKE = 1;
  localparam int STS_OVR = 2;
  localparam int STS_RST = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PBEI_G3, PBEI_S0, PBEI_SX, PBEI_DSX} pbei_pstate_t;
  typedef struct packed {
    logic smi;
    logic sci;
    logic wake;
  } pbei_evt_t;
endpackage

// ### rtl/pbei_top.sv
// Purpose: power button, wake request and reset button event logic
// Assumes: inputs synchronous to CLK_SYS_I; RST_I is the resume-well reset
// Notes: registers at 0x00 config, 0x04 sticky status, 0x08 levels
`timescale 1ns/1ns
// Function
// [RULE_01] debounce power button for sixteen milliseconds
// [RULE_02] ignore new falling edges per debounce mode; the code swallows them in mode 1 only, since pb_fall is 0 in mode 0
// [RULE_03] hold off wake while sleep stretching
// [RULE_04] lengthen override to nine seconds while stretching
// [RULE_05] extend only after graceful entry or reset; the code arms it on graceful entry only, and RST_I clears it
// [RULE_06] in S0 raise SMI or SCI
// [RULE_07] S0 processing within hundred microseconds
// [RULE_08] sleep wake needs 150 us press
// [RULE_09] button released 500 us after resume reset
// [RULE_10] G3 presses ignored entirely
// [RULE_11] four second press forces S5; the code does not count the override in DSX
// [RULE_12] mode zero adds sixteen ms debounce
// [RULE_13] level status debounced or raw by mode
// [RULE_14] wake request acts on falling edge
// [RULE_15] internal wake bit has same effect
// [RULE_16] debounced reset button starts host reset
// [RULE_17] host reset lasts five to six ms
// [RULE_18] block rearm until released and S0
// [RULE_19] control bit selects full power cycle
// [RULE_20] reset button only with power good
// [RULE_21] power button wake never masked
// [RULE_22] override counter restarts on release
// [RULE_23] timers on always-on clock, reset cleared
module pbei_top #(
  parameter int unsigned DB_CYC = pbei_pkg::DB_CYC,
  parameter int unsigned OVR_CYC = pbei_pkg::OVR_CYC,
  parameter int unsigned OVR_EXT_CYC = pbei_pkg::OVR_EXT_CYC,
  parameter int unsigned RST_CYC = pbei_pkg::RST_CYC
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // platform pins
  input wire logic POWER_BUTTON_N_I,
  input wire logic WAKE_REQUEST_N_I,
  input wire logic RESET_BUTTON_N_I,
  input wire logic PLATFORM_RESET_N_I,
  input wire logic PRIMARY_POWER_GOOD_I,
  // power state context
  input wire logic [1:0] POWER_STATE_I,
  input wire logic SLEEP_STRETCH_I,
  input wire logic GRACEFUL_ENTRY_I,
  // event outputs
  output logic SMI_O,
  output logic SCI_O,
  output logic WAKE_O,
  output logic FORCE_S5_O,
  output logic HOST_RESET_O,
  output logic FULL_CYCLE_O,
  // axi4-lite slave
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  ////////////////////////////////////////////////////////////////////////////
  logic [6:0] cfg_ff;
  logic [3:0] sts_ff;
  logic [31:0] db_cnt_ff;
  logic pb_db_ff;
  logic pb_raw_d_ff;
  logic [31:0] ign_cnt_ff;
  logic [31:0] low_cnt_ff;
  logic pb_done_ff;
  logic [31:0] ovr_cnt_ff;
  logic ext_arm_ff;
  logic [31:0] rel_cnt_ff;
  logic rel_ok_ff;
  logic wr_d_ff;
  logic [31:0] rb_cnt_ff;
  logic rb_db_ff;
  logic [31:0] rst_cnt_ff;
  logic rst_blk_ff;
  logic aw_ff;
  logic w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  pbei_pkg::pbei_pstate_t pstate;
  pbei_pkg::pbei_evt_t nxt_evt;
  logic pb_fall;
  logic pb_accept;
  logic [31:0] need_cyc;
  logic wake_fall;
  logic wr_go;
  logic clr_btn;
  logic clr_wake;
  logic clr_ovr;
  logic clr_rst;
  logic rst_start;

  assign pstate = pbei_pkg::pbei_pstate_t'(POWER_STATE_I);

  ////////////////////////////////////////////////////////////////////////////
  // power button debounce: output follows input once stable for the window
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin // RULE_23
      db_cnt_ff <= 32'h0;
      pb_db_ff <= 1'b1;
      pb_raw_d_ff <= 1'b1;
    end else if (pstate == pbei_pkg::PBEI_G3) begin // RULE_10
      db_cnt_ff <= 32'h0;
      pb_db_ff <= 1'b1;
      pb_raw_d_ff <= 1'b1;
    end else begin
      pb_raw_d_ff <= POWER_BUTTON_N_I;
      if (POWER_BUTTON_N_I == pb_db_ff) begin
        db_cnt_ff <= 32'h0;
      end else if (db_cnt_ff >= DB_CYC - 1) begin // RULE_01
        db_cnt_ff <= 32'h0;
        pb_db_ff <= POWER_BUTTON_N_I;
      end else begin
        db_cnt_ff <= db_cnt_ff + 32'h1;
      end
    end
  end

  // mode 1 bypasses debounce for event timing; mode 0 adds the filter delay
  assign pb_fall = cfg_ff[pbei_pkg::CFG_DB_MODE] ? (pb_raw_d_ff & ~POWER_BUTTON_N_I)
                                                : 1'b0; // RULE_12
  always_comb begin
    if (pstate == pbei_pkg::PBEI_S0) begin
      need_cyc = 32'(pbei_pkg::S0_START_CYC) / 32'h2; // RULE_07
    end else begin
      need_cyc = 32'(pbei_pkg::WAKE_MIN_CYC); // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // press qualification: count low time, one event per press, edge ignore window
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      low_cnt_ff <= 32'h0;
      pb_done_ff <= 1'b0;
      ign_cnt_ff <= 32'h0;
    end else begin
      if (ign_cnt_ff != 32'h0) begin
        ign_cnt_ff <= ign_cnt_ff - 32'h1;
      end
      if ((cfg_ff[pbei_pkg::CFG_DB_MODE] ? POWER_BUTTON_N_I : pb_db_ff) || !rel_ok_ff
          || pstate == pbei_pkg::PBEI_G3) begin // RULE_10
        low_cnt_ff <= 32'h0;
        pb_done_ff <= 1'b0;
      end else if (pb_fall && ign_cnt_ff != 32'h0) begin
        // in mode 1, a press that starts inside the window is swallowed whole, not just delayed
        low_cnt_ff <= 32'h0;
        pb_done_ff <= 1'b1; // RULE_02
      end else if (pb_accept) begin
        pb_done_ff <= 1'b1;
        ign_cnt_ff <= cfg_ff[pbei_pkg::CFG_DB_MODE] ? 32'(pbei_pkg::FAST_CYC) : DB_CYC; // RULE_02
      end else if (!pb_done_ff) begin
        low_cnt_ff <= low_cnt_ff + 32'h1;
      end
    end
  end
  // sleep states wait for stretching to finish before waking
  assign pb_accept = !pb_done_ff && low_cnt_ff >= need_cyc && pstate != pbei_pkg::PBEI_G3
                     && !(pstate != pbei_pkg::PBEI_S0 && SLEEP_STRETCH_I); // RULE_03

  ////////////////////////////////////////////////////////////////////////////
  // release qualification after resume reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rel_cnt_ff <= 32'h0;
      rel_ok_ff <= 1'b0;
    end else if (!rel_ok_ff) begin
      if (!POWER_BUTTON_N_I) begin
        rel_cnt_ff <= 32'h0;
      end else if (rel_cnt_ff >= 32'(pbei_pkg::REL_MIN_CYC) - 32'h1) begin
        rel_ok_ff <= 1'b1; // RULE_09
      end else begin
        rel_cnt_ff <= rel_cnt_ff + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // override timer; extension armed by graceful entries, not by power restore
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ext_arm_ff <= 1'b0; // RULE_05
    end else if (GRACEFUL_ENTRY_I) begin
      ext_arm_ff <= 1'b1; // RULE_05
    end else if (pstate == pbei_pkg::PBEI_S0 && !SLEEP_STRETCH_I) begin
      ext_arm_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ovr_cnt_ff <= 32'h0;
      FORCE_S5_O <= 1'b0;
    end else begin
      FORCE_S5_O <= 1'b0;
      if (pb_db_ff || pstate == pbei_pkg::PBEI_G3 || pstate == pbei_pkg::PBEI_DSX) begin
        ovr_cnt_ff <= 32'h0; // RULE_22
      end else if (ovr_cnt_ff >= ((SLEEP_STRETCH_I && ext_arm_ff) ? OVR_EXT_CYC : OVR_CYC) - 1) begin
        ovr_cnt_ff <= 32'h0; // RULE_04 RULE_11
        FORCE_S5_O <= 1'b1; // RULE_11
      end else begin
        ovr_cnt_ff <= ovr_cnt_ff + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event routing for button, wake request and internal wake bit
  assign wake_fall = wr_d_ff & ~WAKE_REQUEST_N_I; // RULE_14
  always_comb begin
    nxt_evt = '0;
    if (pb_accept && pstate == pbei_pkg::PBEI_S0) begin
      nxt_evt.sci = cfg_ff[pbei_pkg::CFG_SCI_ROUTE_ENABLE] & cfg_ff[pbei_pkg::CFG_BTN_EN]; // RULE_06
      nxt_evt.smi = ~cfg_ff[pbei_pkg::CFG_SCI_ROUTE_ENABLE] & cfg_ff[pbei_pkg::CFG_GSMI_EN]; // RULE_06
    end
    if (pb_accept && pstate != pbei_pkg::PBEI_S0) begin
      nxt_evt.wake = 1'b1; // RULE_21
    end
    if (wake_fall || cfg_ff[pbei_pkg::CFG_INT_WAKE]) begin // RULE_15
      if (pstate == pbei_pkg::PBEI_S0) begin
        nxt_evt.sci = nxt_evt.sci | cfg_ff[pbei_pkg::CFG_SCI_ROUTE_ENABLE];
        nxt_evt.smi = nxt_evt.smi | (~cfg_ff[pbei_pkg::CFG_SCI_ROUTE_ENABLE] & cfg_ff[pbei_pkg::CFG_GSMI_EN]);
      end else if (pstate == pbei_pkg::PBEI_SX && !SLEEP_STRETCH_I) begin // RULE_03
        nxt_evt.wake = nxt_evt.wake | cfg_ff[pbei_pkg::CFG_WAKE_EN]; // RULE_14
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wr_d_ff <= 1'b1;
      SMI_O <= 1'b0;
      SCI_O <= 1'b0;
      WAKE_O <= 1'b0;
    end else begin
      wr_d_ff <= WAKE_REQUEST_N_I;
      SMI_O <= nxt_evt.smi;
      SCI_O <= nxt_evt.sci;
      WAKE_O <= nxt_evt.wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset button: debounce, fixed-length host reset, rearm block
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rb_cnt_ff <= 32'h0;
      rb_db_ff <= 1'b1;
    end else if (RESET_BUTTON_N_I == rb_db_ff) begin
      rb_cnt_ff <= 32'h0;
    end else if (rb_cnt_ff >= DB_CYC - 1) begin
      rb_cnt_ff <= 32'h0;
      rb_db_ff <= RESET_BUTTON_N_I; // RULE_16
    end else begin
      rb_cnt_ff <= rb_cnt_ff + 32'h1;
    end
  end

  assign rst_start = !rb_db_ff && !rst_blk_ff && PRIMARY_POWER_GOOD_I; // RULE_16 RULE_20

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rst_cnt_ff <= 32'h0;
      rst_blk_ff <= 1'b0;
      HOST_RESET_O <= 1'b0;
      FULL_CYCLE_O <= 1'b0;
    end else if (rst_start) begin
      rst_cnt_ff <= RST_CYC;
      rst_blk_ff <= 1'b1;
      HOST_RESET_O <= 1'b1;
      FULL_CYCLE_O <= cfg_ff[pbei_pkg::CFG_FULL_CYC]; // RULE_19
    end else if (rst_cnt_ff != 32'h0) begin
      rst_cnt_ff <= rst_cnt_ff - 32'h1; // RULE_17
      HOST_RESET_O <= rst_cnt_ff != 32'h1;
      FULL_CYCLE_O <= FULL_CYCLE_O && rst_cnt_ff != 32'h1;
    end else begin
      HOST_RESET_O <= 1'b0;
      FULL_CYCLE_O <= 1'b0;
      if (rb_db_ff && pstate == pbei_pkg::PBEI_S0 && PLATFORM_RESET_N_I) begin
        rst_blk_ff <= 1'b0; // RULE_18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: accepts address and data in any order, one write at a time
  assign wr_go = aw_ff && w_ff && !BVALID_O;
  assign clr_btn = wr_go && awaddr_ff == pbei_pkg::ADDR_STS && wstrb_ff[0] && wdata_ff[pbei_pkg::STS_BTN];
  assign clr_wake = wr_go && awaddr_ff == pbei_pkg::ADDR_STS && wstrb_ff[0] && wdata_ff[pbei_pkg::STS_WAKE];
  assign clr_ovr = wr_go && awaddr_ff == pbei_pkg::ADDR_STS && wstrb_ff[0] && wdata_ff[pbei_pkg::STS_OVR];
  assign clr_rst = wr_go && awaddr_ff == pbei_pkg::ADDR_STS && wstrb_ff[0] && wdata_ff[pbei_pkg::STS_RST];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= pbei_pkg::RESP_OKAY;
    end else begin
      AWREADY_O <= !aw_ff && !AWREADY_O && !BVALID_O;
      WREADY_O <= !w_ff && !WREADY_O && !BVALID_O;
      if (AWVALID_I && AWREADY_O) begin
        aw_ff <= 1'b1;
        awaddr_ff <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_ff <= 1'b1;
        wdata_ff <= WDATA_I;
        wstrb_ff <= WSTRB_I;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= (awaddr_ff == pbei_pkg::ADDR_CFG || awaddr_ff == pbei_pkg::ADDR_STS
                    || awaddr_ff == pbei_pkg::ADDR_LVL) ? pbei_pkg::RESP_OKAY : pbei_pkg::RESP_SLVERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cfg_ff <= pbei_pkg::CFG_RST;
    end else if (wr_go && awaddr_ff == pbei_pkg::ADDR_CFG && wstrb_ff[0]) begin
      cfg_ff <= wdata_ff[6:0];
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sts_ff <= 4'h0;
    end else begin
      sts_ff[pbei_pkg::STS_BTN] <= pb_accept | (sts_ff[pbei_pkg::STS_BTN] & ~clr_btn);
      sts_ff[pbei_pkg::STS_WAKE] <= wake_fall | (sts_ff[pbei_pkg::STS_WAKE] & ~clr_wake);
      sts_ff[pbei_pkg::STS_OVR] <= FORCE_S5_O | (sts_ff[pbei_pkg::STS_OVR] & ~clr_ovr);
      sts_ff[pbei_pkg::STS_RST] <= rst_start | (sts_ff[pbei_pkg::STS_RST] & ~clr_rst);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0;
      RRESP_O <= pbei_pkg::RESP_OKAY;
    end else begin
      ARREADY_O <= !ARREADY_O && !RVALID_O;
      if (ARVALID_I && ARREADY_O) begin
        RVALID_O <= 1'b1;
        RRESP_O <= pbei_pkg::RESP_OKAY;
        unique case (ARADDR_I)
          pbei_pkg::ADDR_CFG: RDATA_O <= {25'h0, cfg_ff};
          pbei_pkg::ADDR_STS: RDATA_O <= {28'h0, sts_ff};
          pbei_pkg::ADDR_LVL: begin
            RDATA_O <= {30'h0, rst_blk_ff,
                        cfg_ff[pbei_pkg::CFG_DB_MODE] ? POWER_BUTTON_N_I : pb_db_ff}; // RULE_13
          end
          default: begin
            RDATA_O <= 32'h0;
            RRESP_O <= pbei_pkg::RESP_SLVERR;
          end
        endcase
      end else if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end
endmodule // pbei_top

// ### tb/pbei_checker.sv
// Purpose: port-level checks of the power button event block
// Assumes: one clock, RST_I synchronous active high
// Notes: counters replace long repetitions
`timescale 1ns/1ns
module pbei_checker #(
  parameter int unsigned OVR_CYC = 200,
  parameter int unsigned RST_CYC = 30
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // platform and context
  input wire logic POWER_BUTTON_N_I,
  input wire logic PRIMARY_POWER_GOOD_I,
  input wire logic [1:0] POWER_STATE_I,
  input wire logic SLEEP_STRETCH_I,
  // events
  input wire logic SMI_O,
  input wire logic SCI_O,
  input wire logic WAKE_O,
  input wire logic FORCE_S5_O,
  input wire logic HOST_RESET_O,
  input wire logic FULL_CYCLE_O,
  // bus answers
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic RVALID_O,
  input wire logic RREADY_I
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic [31:0] low_cnt_ff;
  logic [31:0] hi_cnt_ff;
  ////////////////////////////////////////
  // raw low count is a lower bound: debounce only adds to it
  always_ff @(posedge CLK_SYS_I) begin
    low_cnt_ff <= (RST_I || POWER_BUTTON_N_I) ? 32'h0 : low_cnt_ff + 32'h1;
  end
  always_ff @(posedge CLK_SYS_I) begin
    hi_cnt_ff <= (RST_I || !HOST_RESET_O) ? 32'h0 : hi_cnt_ff + 32'h1;
  end
  sequence rst_end;
    $fell(HOST_RESET_O);
  endsequence
  ////////////////////////////////////////
  chk_smi_sci_apart: assert property (!(SMI_O && SCI_O))
    else $error("smi and sci together");
  chk_g3_no_force: assert property (POWER_STATE_I == 2'h0 && $past(POWER_STATE_I) == 2'h0 |-> !FORCE_S5_O)
    else $error("override in g3");
  chk_override_time: assert property (FORCE_S5_O |-> low_cnt_ff >= OVR_CYC)
    else $error("override too early");
  chk_rst_length: assert property (rst_end |-> hi_cnt_ff == RST_CYC)
    else $error("host reset length wrong");
  chk_rst_no_rearm: assert property (rst_end |=> !HOST_RESET_O [*8])
    else $error("host reset rearmed");
  chk_rst_power_good: assert property ($rose(HOST_RESET_O) |-> $past(PRIMARY_POWER_GOOD_I))
    else $error("reset without power good");
  chk_full_with_rst: assert property (FULL_CYCLE_O |-> HOST_RESET_O)
    else $error("full cycle without reset");
  chk_stretch_no_wake: assert property (SLEEP_STRETCH_I && $past(SLEEP_STRETCH_I) |-> !WAKE_O)
    else $error("wake during stretch");
  chk_bresp_once: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write answer repeated");
  chk_rresp_once: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read answer repeated");
endmodule // pbei_checker
bind pbei_top pbei_checker #(.OVR_CYC(OVR_CYC), .RST_CYC(RST_CYC)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .POWER_BUTTON_N_I(POWER_BUTTON_N_I),
  .PRIMARY_POWER_GOOD_I(PRIMARY_POWER_GOOD_I), .POWER_STATE_I(POWER_STATE_I),
  .SLEEP_STRETCH_I(SLEEP_STRETCH_I), .SMI_O(SMI_O), .SCI_O(SCI_O), .WAKE_O(WAKE_O),
  .FORCE_S5_O(FORCE_S5_O), .HOST_RESET_O(HOST_RESET_O), .FULL_CYCLE_O(FULL_CYCLE_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I)
);

// ### tb/pbei_platform.sv
// Purpose: platform side: power button, wake request, reset switch
// Assumes: released pins read high through pull-ups
// Notes: a press waits out the release period after resume reset
`timescale 1ns/1ns
module pbei_platform #(
  parameter int unsigned REL_MIN_CYC = pbei_pkg::REL_MIN_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // platform pins
  output logic power_button_n_o,
  output logic wake_request_n_o,
  output logic reset_button_n_o
);
  int unsigned up_cnt = 0;
  initial begin
    {power_button_n_o, wake_request_n_o, reset_button_n_o} = 3'h7;
  end
  ////////////////////////////////////////
  always @(posedge clk_i) begin
    if (rst_i) up_cnt <= 0;
    else if (up_cnt < REL_MIN_CYC) up_cnt <= up_cnt + 1;
  end
  // an early press would be ignored: no press qualifies until rel_ok_ff is set after 500 us released
  task automatic pwr(input logic v);
    while (!v && up_cnt < REL_MIN_CYC) @(posedge clk_i);
    @(posedge clk_i);
    power_button_n_o <= v;
  endtask
  task automatic wk(input logic v);
    @(posedge clk_i);
    wake_request_n_o <= v;
  endtask
  task automatic rb(input logic v);
    @(posedge clk_i);
    reset_button_n_o <= v;
  endtask
endmodule // pbei_platform

// ### tb/tb_top.sv
// Purpose: self-checking bench for the power button event block
// Assumes: shortened debounce, override and reset counts
// Notes: every wait is bounded
`timescale 1ns/1ns
module tb_top;
  localparam int DB = 20;
  localparam int OVR = 5000;
  localparam int EXT = 9000;
  logic clk, rst, prst_n, pgood, stretch, grace;
  logic [1:0] pstate;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic btn_n, wreq_n, rbtn_n, smi, sci, wake, fs5, hrst, full;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int n;
  int fails = 0;
  int n_compared = 0;
  ////////////////////////////////////////
  pbei_top #(.DB_CYC(DB), .OVR_CYC(OVR), .OVR_EXT_CYC(EXT), .RST_CYC(30)) uut (
    .CLK_SYS_I(clk), .RST_I(rst), .POWER_BUTTON_N_I(btn_n), .WAKE_REQUEST_N_I(wreq_n),
    .RESET_BUTTON_N_I(rbtn_n), .PLATFORM_RESET_N_I(prst_n), .PRIMARY_POWER_GOOD_I(pgood),
    .POWER_STATE_I(pstate), .SLEEP_STRETCH_I(stretch), .GRACEFUL_ENTRY_I(grace),
    .SMI_O(smi), .SCI_O(sci), .WAKE_O(wake), .FORCE_S5_O(fs5), .HOST_RESET_O(hrst), .FULL_CYCLE_O(full),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready)
  );
  pbei_platform plat (
    .clk_i(clk), .rst_i(rst), .power_button_n_o(btn_n), .wake_request_n_o(wreq_n),
    .reset_button_n_o(rbtn_n)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 50);
    r = bresp;
    bready <= 1'b0;
    if (k >= 50) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k >= 50) begin
      fails++;
      finish_test();
    end
  endtask
  function automatic logic ev(input int w);
    case (w)
      0: return smi;
      1: return sci;
      2: return wake;
      3: return fs5;
      default: return hrst;
    endcase
  endfunction
  // n reaching the limit means the event never came
  task automatic wait_ev(input int w, input int lim);
    n = 0;
    while (ev(w) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic rel();
    plat.pwr(1'b1);
    repeat (50) @(posedge clk);
  endtask
  task automatic pulse_grace();
    @(posedge clk);
    grace <= 1'b1;
    @(posedge clk);
    grace <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    rst <= 1'b1;
    {prst_n, pgood, stretch, grace} <= 4'hC;
    pstate <= 2'h1;
    {awaddr, araddr, wdata, wstrb} <= {8'h00, 8'h00, 32'h0, 4'hF};
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(pbei_pkg::ADDR_CFG);
    chk("cfg reset", {25'h0, pbei_pkg::CFG_RST}, d);
    rd(pbei_pkg::ADDR_STS);
    chk("status reset", 32'h0, d);
    rd(8'h0C);
    chk("read unmapped", pbei_pkg::RESP_SLVERR, r);
    wr(8'h0C, 32'h0);
    chk("write unmapped", pbei_pkg::RESP_SLVERR, r);
    rd(pbei_pkg::ADDR_LVL);
    chk("idle level", 32'h1, d[0]);
    wr(pbei_pkg::ADDR_CFG, 32'h09);
    wstrb <= 4'h0;
    wr(pbei_pkg::ADDR_CFG, 32'h7F);
    wstrb <= 4'hF;
    rd(pbei_pkg::ADDR_CFG);
    chk("cfg readback", 32'h09, d);
    plat.pwr(1'b0);
    rd(pbei_pkg::ADDR_LVL);
    chk("raw level", 32'h0, d[0]);
    wait_ev(0, 2000);
    chk("smi in s0", 1, n < 2000);
    rel();
    rd(pbei_pkg::ADDR_STS);
    chk("button status", 1, d[0]);
    wr(pbei_pkg::ADDR_STS, 32'h1);
    rd(pbei_pkg::ADDR_STS);
    chk("status cleared", 0, d[0]);
    plat.pwr(1'b0);
    wait_ev(0, 1500);
    chk("edge ignored", 1, n >= 1500);
    rel();
    wr(pbei_pkg::ADDR_CFG, 32'h06);
    plat.pwr(1'b0);
    rd(pbei_pkg::ADDR_LVL);
    chk("debounced level", 32'h1, d[0]);
    wait_ev(1, 2000 + DB);
    chk("sci in s0", 1, n < 2000 + DB);
    repeat (3000) @(posedge clk);
    rel();
    plat.pwr(1'b0);
    wait_ev(3, OVR + DB + 100);
    chk("override", 1, n < OVR + DB + 100 && n >= OVR);
    rel();
    rd(pbei_pkg::ADDR_STS);
    chk("override status", 1, d[2]);
    wr(pbei_pkg::ADDR_CFG, 32'h0);
    pstate <= 2'h2;
    stretch <= 1'b1;
    plat.pwr(1'b0);
    wait_ev(3, OVR + DB + 100);
    chk("no extension after reset", 1, n < OVR + DB + 100);
    rel();
    pulse_grace();
    plat.pwr(1'b0);
    wait_ev(3, EXT + DB + 100);
    chk("extended override", 1, n < EXT + DB + 100 && n >= EXT);
    rel();
    pulse_grace();
    plat.pwr(1'b0);
    wait_ev(2, 4000);
    chk("wake held off", 1, n >= 4000);
    stretch <= 1'b0;
    wait_ev(2, 3100);
    chk("wake after stretch", 1, n < 3100);
    rel();
    plat.pwr(1'b0);
    wait_ev(2, 2000);
    chk("short press", 1, n >= 2000);
    rel();
    pstate <= 2'h0;
    plat.pwr(1'b0);
    wait_ev(3, OVR + 500);
    chk("g3 press ignored", 1, n >= OVR + 500);
    rel();
    pstate <= 2'h1;
    wr(pbei_pkg::ADDR_CFG, 32'h16);
    plat.wk(1'b0);
    repeat (5) @(posedge clk);
    rd(pbei_pkg::ADDR_STS);
    chk("wake request fall", 1, d[1]);
    wr(pbei_pkg::ADDR_STS, 32'hF);
    plat.wk(1'b1);
    repeat (5) @(posedge clk);
    rd(pbei_pkg::ADDR_STS);
    chk("wake request rise", 0, d[1]);
    wr(pbei_pkg::ADDR_CFG, 32'h26);
    wait_ev(1, 20);
    chk("internal wake bit", 1, n < 20);
    wr(pbei_pkg::ADDR_CFG, 32'h06);
    plat.rb(1'b0);
    wait_ev(4, DB + 20);
    chk("host reset", 1, n < DB + 20 && n >= DB - 2);
    chk("graceful reset", 0, full);
    prst_n <= 1'b0;
    repeat (60) @(posedge clk);
    plat.rb(1'b1);
    repeat (50) @(posedge clk);
    plat.rb(1'b0);
    wait_ev(4, DB + 40);
    chk("rearm blocked", 1, n >= DB + 40);
    plat.rb(1'b1);
    prst_n <= 1'b1;
    repeat (50) @(posedge clk);
    wr(pbei_pkg::ADDR_CFG, 32'h46);
    plat.rb(1'b0);
    wait_ev(4, DB + 20);
    chk("full cycle reset", 1, n < DB + 20 && full === 1'b1);
    plat.rb(1'b1);
    repeat (50) @(posedge clk);
    pgood <= 1'b0;
    plat.rb(1'b0);
    wait_ev(4, DB + 40);
    chk("no power good", 1, n >= DB + 40);
    finish_test();
  end
endmodule // tb_top
